// ==== design/led_matrix_defs.svh ====
// constants for the led matrix brightness, breath, detect and interrupt logic
// assumes a 25 MHz core clock; included by bare name
`ifndef LED_MATRIX_DEFS_SVH
`define LED_MATRIX_DEFS_SVH

// geometry
`define DOT_COUNT          96
`define ONOFF_BYTES        12
`define PROFILE_COUNT      3
`define PROFILE_REG_BYTES  12

// register pages
`define PAGE_ONOFF         2'h0
`define PAGE_PWM           2'h1
`define PAGE_MODE          2'h2
`define PAGE_FUNCTION      2'h3

// page 0 offsets
`define OFF_ONOFF_BASE     8'h00
`define OFF_OPEN_BASE      8'h18
`define OFF_SHORT_BASE     8'h30

// function page offsets
`define OFF_CHIP_CONFIGURATION    8'h00
`define OFF_GLOBAL_CURRENT_SCALE  8'h01
`define OFF_PROFILE_FIRST         8'h02
`define OFF_PROFILE_LAST          8'h0d
`define OFF_PROFILE_TIME_UPDATE   8'h0e
`define OFF_INTERRUPT_ENABLE_MASK 8'hf0
`define OFF_INTERRUPT_FLAGS       8'hf1

// commit value for the time update register
`define TIME_UPDATE_KEY    8'h00

// chip configuration fields
`define CFG_BREATH_ENABLE_BIT   1
`define CFG_DETECT_TRIGGER_BIT  2

// mask and flag fields
`define IRQ_OPEN_BIT       0
`define IRQ_SHORT_BIT      1
`define IRQ_PROFILE_BIT    2
`define IRQ_AUTO_CLEAR_BIT 5
`define IRQ_SOURCE_MASK    8'h1f

// reset values
`define RESET_BYTE         8'h00

// timing
`define CLK_KHZ            25000
`define DETECT_TIME_US     3264
`define AUTO_CLEAR_MS      8
`define BREATH_UNIT_MS     210
`define BREATH_LEVELS      256
`define DETECT_CYCLES      ((`DETECT_TIME_US * `CLK_KHZ + 999) / 1000)
`define AUTO_CLEAR_CYCLES  (`AUTO_CLEAR_MS * `CLK_KHZ)
`define BREATH_STEP_CYCLES ((`BREATH_UNIT_MS * `CLK_KHZ) / `BREATH_LEVELS)

`endif

// ==== design/led_matrix_pkg.sv ====
// types shared by the led matrix brightness, breath and interrupt logic
// assumes nothing beyond the constants header
`default_nettype none

package led_matrix_pkg;

    // one register access from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] page;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;

    // active settings of one breath profile
    typedef struct packed {
        logic [2:0]  rise_phase;
        logic [3:0]  hold_on_phase;
        logic [2:0]  fall_phase;
        logic [3:0]  off_phase;
        logic        loop_end_point;
        logic [1:0]  loop_start_phase;
        logic [3:0]  loop_count_high;
        logic [7:0]  loop_count_low;
    } profile_cfg_t;

    typedef enum logic [4:0] {
        PH_RISE = 5'b00001,
        PH_HOLD = 5'b00010,
        PH_FALL = 5'b00100,
        PH_OFF  = 5'b01000,
        PH_STOP = 5'b10000
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic        extra;
        logic [7:0]  step;
        logic [7:0]  unit;
        logic [15:0] cyc;
        logic [11:0] loops;
        logic [7:0]  level;
        logic        done;
    } profile_state_t;

    typedef struct packed {
        logic        busy;
        logic [23:0] count;
        logic        done;
    } timer_state_t;

endpackage : led_matrix_pkg

`default_nettype wire

// ==== design/shot_timer.sv ====
// one-shot cycle timer: start arms it, stop abandons it, done pulses at expiry
// assumes length_in is held stable while the timer runs
`default_nettype none

module shot_timer (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // control
    input  wire logic        start_in,
    input  wire logic        stop_in,
    input  wire logic [23:0] length_in,
    // status
    output logic             done_out,
    output logic             busy_out
);
    import led_matrix_pkg::*;

    timer_state_t st;
    timer_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (stop_in) begin
            next_st.busy  = 1'b0;
            next_st.count = 24'h000000;
        end else if (start_in) begin
            next_st.busy  = 1'b1;
            next_st.count = 24'h000000;
        end else if (st.busy) begin
            if (st.count >= length_in - 24'h000001) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done_out = st.done;
    assign busy_out = st.busy;

endmodule : shot_timer

`default_nettype wire

// ==== design/breath_profile.sv ====
// one auto breath profile: four-phase ramp generator with loop counting
// assumes cfg_in changes only together with a restart pulse
`default_nettype none

module breath_profile #(
    parameter logic [15:0] STEP_CYCLES = 16'h501b
) (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // control
    input  wire logic                         restart_in,
    input  wire logic                         run_in,
    input  wire led_matrix_pkg::profile_cfg_t cfg_in,
    // outputs
    output logic [7:0]                        level_out,
    output logic                              done_out
);
    import led_matrix_pkg::*;

    profile_state_t st;
    profile_state_t next_st;
    logic [7:0]     units;
    logic [11:0]    target;
    logic           phase_end;
    logic [11:0]    loops_inc;

    // phase length in 0.21 s units; hold and off may be zero
    function automatic logic [7:0] span(input logic [3:0] code, input logic zero_ok);
        logic [3:0] e;
        e = zero_ok ? code - 4'h1 : code;
        if (zero_ok && code == 4'h0) begin
            span = 8'h00;
        end else if (e > 4'h7) begin
            span = 8'h80;
        end else begin
            span = 8'h01 << e[2:0];
        end
    endfunction : span

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        target       = {cfg_in.loop_count_high, cfg_in.loop_count_low}; // R8
        loops_inc    = st.loops + 12'h001;
        units        = 8'h00;
        unique case (st.phase)
            PH_RISE: units = span({1'b0, cfg_in.rise_phase}, 1'b0); // R6
            PH_HOLD: units = span(cfg_in.hold_on_phase, 1'b1);
            PH_FALL: units = span({1'b0, cfg_in.fall_phase}, 1'b0);
            PH_OFF:  units = span(cfg_in.off_phase, 1'b1);
            PH_STOP: units = 8'h00;
        endcase
        phase_end = (units == 8'h00) ||
                    (st.step == 8'hff && st.unit == units - 8'h01 && st.cyc == STEP_CYCLES - 16'h0001);
        if (restart_in) begin
            next_st.extra = 1'b0;
            next_st.step  = 8'h00;
            next_st.unit  = 8'h00;
            next_st.cyc   = 16'h0000;
            next_st.loops = 12'h000;
            unique case (cfg_in.loop_start_phase) // R7
                2'h0: next_st.phase = PH_RISE;
                2'h1: next_st.phase = PH_HOLD;
                2'h2: next_st.phase = PH_FALL;
                2'h3: next_st.phase = PH_OFF;
            endcase
        end else if (run_in && st.phase != PH_STOP) begin
            if (phase_end) begin
                next_st.step = 8'h00;
                next_st.unit = 8'h00;
                next_st.cyc  = 16'h0000;
                unique case (st.phase) // R9
                    PH_RISE: begin
                        if (st.extra) begin
                            next_st.phase = PH_STOP;
                            next_st.done  = 1'b1;
                        end else begin
                            next_st.phase = PH_HOLD;
                        end
                    end
                    PH_HOLD: next_st.phase = PH_FALL;
                    PH_FALL: begin
                        next_st.loops = loops_inc;
                        next_st.phase = PH_OFF;
                        if (target != 12'h000 && loops_inc == target) begin // R8
                            if (cfg_in.loop_end_point) begin
                                next_st.extra = 1'b1;
                            end else begin
                                next_st.phase = PH_STOP;
                                next_st.done  = 1'b1;
                            end
                        end
                    end
                    PH_OFF:  next_st.phase = PH_RISE;
                    PH_STOP: next_st.phase = PH_STOP;
                endcase
            end else if (st.cyc != STEP_CYCLES - 16'h0001) begin
                next_st.cyc = st.cyc + 16'h0001;
            end else if (st.unit != units - 8'h01) begin
                next_st.cyc  = 16'h0000;
                next_st.unit = st.unit + 8'h01;
            end else begin
                next_st.cyc  = 16'h0000;
                next_st.unit = 8'h00;
                next_st.step = st.step + 8'h01;
            end
        end
        unique case (next_st.phase) // R6
            PH_RISE: next_st.level = next_st.step;
            PH_HOLD: next_st.level = 8'hff;
            PH_FALL: next_st.level = 8'hff - next_st.step;
            PH_OFF:  next_st.level = 8'h00;
            PH_STOP: next_st.level = cfg_in.loop_end_point ? 8'hff : 8'h00; // R7
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st       <= '0;
            st.phase <= PH_RISE;
        end else begin
            st <= next_st;
        end
    end

    assign level_out = st.level;
    assign done_out  = st.done;

endmodule : breath_profile

`default_nettype wire

// ==== design/led_dot_mode_breath_detect_irq.sv ====
// led matrix dot brightness, breath profile selection, open/short detect and interrupt
// assumes a decoded register port from the serial interface and level inputs from the detect comparators
`default_nettype none
`include "led_matrix_defs.svh"

// Overview of operation
// R1: each dot has own 8-bit brightness
// R2: global scale applies to all row sources
// R3: mode 00 or breath off gives PWM
// R4: breath enable bit turns breathing on/off
// R5: modes 01/10/11 pick profiles one/two/three
// R6: four phases with programmable durations
// R7: loop start phase, end point, repeat count
// R8: count is high*256+low, zero means endless
// R9: off-rise-hold-fall order, fall counts a loop
// R10: timing writes shadowed until update write
// R11: host writes zero to commit timing
// R12: host follows breath enable sequence
// R13: trigger rise captures results after two scans
// R14: disabled dots keep old detect results
// R15: host sets scale to one before detect
// R16: detection single shot, clear then set
// R17: interrupt on masked open/short/profile sources
// R18: open found sets flag and pulls low
// R19: status read or 8ms auto clear releases
// R20: flags clear when interrupt released
// R21: host may load gamma corrected PWM values
// R22: interrupt active low, high when idle
module led_dot_mode_breath_detect_irq #(
    parameter int unsigned DETECT_CYCLES      = `DETECT_CYCLES,
    parameter int unsigned AUTO_CLEAR_CYCLES  = `AUTO_CLEAR_CYCLES,
    parameter int unsigned BREATH_STEP_CYCLES = `BREATH_STEP_CYCLES
) (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    // register port
    input  wire led_matrix_pkg::reg_req_t reg_req_in,
    output logic [7:0]                    reg_rdata_out,
    // detect comparators
    input  wire logic [95:0]              led_open_in,
    input  wire logic [95:0]              led_short_in,
    // matrix drive
    output logic [95:0][7:0]              dot_level_out,
    output logic [95:0]                   dot_enable_out,
    output logic [7:0]                    current_scale_out,
    // interrupt
    output logic                          interrupt_out_n
);
    import led_matrix_pkg::*;

    typedef struct packed {
        logic [7:0]        chip_configuration;
        logic [7:0]        global_current_scale;
        logic [7:0]        interrupt_enable_mask;
        logic [7:0]        interrupt_flags;

        logic [11:0][7:0]  shadow;
        logic [11:0][7:0]  active;

        logic [95:0][7:0]  pwm;
        logic [95:0][1:0]  mode;

        logic [95:0]       dot_on;

        logic [95:0]       open_res;
        logic [95:0]       short_res;
        logic [95:0][7:0]  level;

        logic              trig_prev;
        logic              ben_prev;

        logic              update;

        logic              irq_n;
        logic [7:0]        rdata;
    } core_state_t;

    core_state_t         st;
    core_state_t         next_st;

    profile_cfg_t [2:0]  prof_cfg;
    logic [2:0][7:0]     prof_level;
    logic [2:0]          prof_done;

    logic [95:0][7:0]    dot_sel;

    logic                breath_en;
    logic                restart;

    logic                detect_start;
    logic                detect_done;
    logic                clear_wait_done;

    logic                irq_fall;
    logic                irq_rise;

    logic [7:0]          events;
    logic                flag_read;

    logic                auto_clear;
    logic [7:0]          a;

    // breath run and restart
    assign breath_en = st.chip_configuration[`CFG_BREATH_ENABLE_BIT];
    assign restart   = st.update || (breath_en && !st.ben_prev);

    // three profiles, each fed from its four active timing bytes
    genvar p;
    generate
        for (p = 0; p < `PROFILE_COUNT; p++) begin : g_prof
            assign prof_cfg[p] = {st.active[4*p][7:5], st.active[4*p][4:1],
                                  st.active[4*p+1][7:5], st.active[4*p+1][4:1],
                                  st.active[4*p+2][6], st.active[4*p+2][5:4],
                                  st.active[4*p+2][3:0], st.active[4*p+3]};

            breath_profile #(
                .STEP_CYCLES (16'(BREATH_STEP_CYCLES))
            ) u_prof (
                .clk_in     (clk_in),
                .rst_in     (rst_in),
                .restart_in (restart),
                .run_in     (breath_en), // R4
                .cfg_in     (prof_cfg[p]),
                .level_out  (prof_level[p]),
                .done_out   (prof_done[p])
            );
        end
    endgenerate

    // per-dot source selection
    genvar d;
    generate
        for (d = 0; d < `DOT_COUNT; d++) begin : g_dot

            always_comb begin
                if (!st.dot_on[d]) begin
                    dot_sel[d] = 8'h00;
                end else if (!breath_en || st.mode[d] == 2'h0) begin
                    dot_sel[d] = st.pwm[d]; // R3 R1
                end else begin
                    dot_sel[d] = prof_level[st.mode[d] - 2'h1]; // R5
                end
            end
        end
    endgenerate

    // detect capture delay
    shot_timer u_detect_wait (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .start_in  (detect_start),
        .stop_in   (1'b0),
        .length_in (24'(DETECT_CYCLES)), // R13
        .done_out  (detect_done),
        .busy_out  ()
    );

    // auto clear timer
    shot_timer u_auto_clear (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .start_in  (irq_fall),
        .stop_in   (irq_rise),
        .length_in (24'(AUTO_CLEAR_CYCLES)),
        .done_out  (clear_wait_done),
        .busy_out  ()
    );

    always_comb begin
        next_st        = st;
        next_st.update = 1'b0;

        a              = reg_req_in.addr;
        flag_read      = 1'b0;

        // register writes
        if (reg_req_in.wr) begin
            case (reg_req_in.page)
                `PAGE_ONOFF: begin
                    if (a < 8'(`ONOFF_BYTES)) begin
                        next_st.dot_on[{a[3:0], 3'h0} +: 8] = reg_req_in.data;
                    end
                end
                `PAGE_PWM: begin
                    if (a < 8'(`DOT_COUNT)) begin
                        next_st.pwm[a[6:0]] = reg_req_in.data; // R1
                    end
                end
                `PAGE_MODE: begin
                    if (a < 8'(`DOT_COUNT)) begin
                        next_st.mode[a[6:0]] = reg_req_in.data[1:0]; // R5
                    end
                end
                default: begin
                    if (a == `OFF_CHIP_CONFIGURATION) begin
                        next_st.chip_configuration = reg_req_in.data; // R4
                    end else if (a == `OFF_GLOBAL_CURRENT_SCALE) begin
                        next_st.global_current_scale = reg_req_in.data; // R2
                    end else if (a >= `OFF_PROFILE_FIRST && a <= `OFF_PROFILE_LAST) begin
                        next_st.shadow[a[3:0] - 4'h2] = reg_req_in.data; // R10
                    end else if (a == `OFF_PROFILE_TIME_UPDATE && reg_req_in.data == `TIME_UPDATE_KEY) begin
                        next_st.active = st.shadow; // R10
                        next_st.update = 1'b1;
                    end else if (a == `OFF_INTERRUPT_ENABLE_MASK) begin
                        next_st.interrupt_enable_mask = reg_req_in.data;
                    end
                end
            endcase
        end

        // register reads, answered one cycle later
        next_st.rdata = 8'h00;
        if (reg_req_in.rd) begin
            case (reg_req_in.page)
                `PAGE_ONOFF: begin
                    if (a < 8'(`ONOFF_BYTES)) begin
                        next_st.rdata = st.dot_on[{a[3:0], 3'h0} +: 8];
                    end else if (a >= `OFF_OPEN_BASE && a < `OFF_OPEN_BASE + 8'(`ONOFF_BYTES)) begin
                        next_st.rdata = st.open_res[{4'(a - `OFF_OPEN_BASE), 3'h0} +: 8];
                    end else if (a >= `OFF_SHORT_BASE && a < `OFF_SHORT_BASE + 8'(`ONOFF_BYTES)) begin
                        next_st.rdata = st.short_res[{4'(a - `OFF_SHORT_BASE), 3'h0} +: 8];
                    end
                end
                `PAGE_PWM: begin
                    if (a < 8'(`DOT_COUNT)) begin
                        next_st.rdata = st.pwm[a[6:0]];
                    end
                end
                `PAGE_MODE: begin
                    if (a < 8'(`DOT_COUNT)) begin
                        next_st.rdata = {6'h00, st.mode[a[6:0]]};
                    end
                end
                default: begin
                    if (a == `OFF_CHIP_CONFIGURATION) begin
                        next_st.rdata = st.chip_configuration;
                    end else if (a == `OFF_GLOBAL_CURRENT_SCALE) begin
                        next_st.rdata = st.global_current_scale;
                    end else if (a >= `OFF_PROFILE_FIRST && a <= `OFF_PROFILE_LAST) begin
                        next_st.rdata = st.shadow[a[3:0] - 4'h2];
                    end else if (a == `OFF_INTERRUPT_ENABLE_MASK) begin
                        next_st.rdata = st.interrupt_enable_mask;
                    end else if (a == `OFF_INTERRUPT_FLAGS) begin
                        next_st.rdata = st.interrupt_flags;
                        flag_read     = 1'b1; // R19
                    end
                end
            endcase
        end

        // open/short detect: one shot per 0-to-1 trigger edge
        next_st.trig_prev = st.chip_configuration[`CFG_DETECT_TRIGGER_BIT];
        detect_start      = next_st.trig_prev && !st.trig_prev; // R13 R16

        next_st.ben_prev  = breath_en;
        events            = 8'h00;

        if (detect_done) begin
            next_st.open_res  = (led_open_in & st.dot_on) | (st.open_res & ~st.dot_on); // R14
            next_st.short_res = (led_short_in & st.dot_on) | (st.short_res & ~st.dot_on); // R14
            events[`IRQ_OPEN_BIT]  = |(led_open_in & st.dot_on);
            events[`IRQ_SHORT_BIT] = |(led_short_in & st.dot_on);
        end

        events[`IRQ_PROFILE_BIT +: 3] = prof_done;

        // interrupt flags: a new event outranks the clear in the same cycle
        auto_clear = clear_wait_done && st.interrupt_enable_mask[`IRQ_AUTO_CLEAR_BIT]; // R19
        if (flag_read || auto_clear) begin
            next_st.interrupt_flags = 8'h00; // R20
        end
        next_st.interrupt_flags = next_st.interrupt_flags
                                | (events & st.interrupt_enable_mask & `IRQ_SOURCE_MASK); // R17 R18

        next_st.irq_n = ~|next_st.interrupt_flags; // R22 R18
        irq_fall      = st.irq_n && !next_st.irq_n;
        irq_rise      = !st.irq_n && next_st.irq_n;

        next_st.level = dot_sel;
    end

    // single state register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st       <= '0;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs from flip-flops
    assign reg_rdata_out     = st.rdata;
    assign dot_level_out     = st.level;
    assign dot_enable_out    = st.dot_on;
    assign current_scale_out = st.global_current_scale; // R2
    assign interrupt_out_n   = st.irq_n; // R22

endmodule : led_dot_mode_breath_detect_irq

`default_nettype wire

// ==== sim/led_irq_monitor.sv ====
// checker for the led matrix block, bound to its top module
// assumes one clock and a synchronous active high reset
`default_nettype none
module led_irq_monitor (
    // watched ports
    input wire logic                     clk_in,
    input wire logic                     rst_in,
    input wire led_matrix_pkg::reg_req_t reg_req_in,
    input wire logic [7:0]               reg_rdata_out,
    input wire logic [95:0][7:0]         dot_level_out,
    input wire logic [95:0]              dot_enable_out,
    input wire logic [7:0]               current_scale_out,
    input wire logic                     interrupt_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    import led_matrix_pkg::*;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic       fr;
    logic       fw;
    logic [7:0] ad;
    assign fr = reg_req_in.rd && reg_req_in.page == 2'h3;
    assign fw = reg_req_in.wr && reg_req_in.page == 2'h3;
    assign ad = reg_req_in.addr;
    scale_follow_a: assert property (fw && ad == 8'h01 |=> current_scale_out == $past(reg_req_in.data))
        else $error("scale not loaded");
    enable_follow_a: assert property (reg_req_in.wr && reg_req_in.page == 2'h0 && ad == 8'h00
        |=> dot_enable_out[7:0] == $past(reg_req_in.data))
        else $error("on/off byte not loaded");
    read_release_a: assert property (fr && ad == 8'hf1 |=> interrupt_out_n)
        else $error("flags read left interrupt low");
    flags_pending_a: assert property (fr && ad == 8'hf1 && !interrupt_out_n |=> reg_rdata_out != 8'h00)
        else $error("interrupt low with no flag");
    flags_clear_a: assert property (fr && ad == 8'hf1 && interrupt_out_n |=> reg_rdata_out == 8'h00)
        else $error("flags kept after release");
    update_reads_zero_a: assert property (fr && ad == 8'h0e |=> reg_rdata_out == 8'h00)
        else $error("time update read not zero");
    reset_idle_a: assert property ($past(rst_in) |-> interrupt_out_n)
        else $error("interrupt low after reset");
    disabled_dark_a: assert property (!dot_enable_out[4] && $past(!dot_enable_out[4]) |-> dot_level_out[4] == 8'h00)
        else $error("disabled dot lit");
endmodule : led_irq_monitor
bind led_dot_mode_breath_detect_irq led_irq_monitor u_mon (.clk_in, .rst_in, .reg_req_in, .reg_rdata_out,
    .dot_level_out, .dot_enable_out, .current_scale_out, .interrupt_out_n);
`default_nettype wire

// ==== sim/host_model.sv ====
// host register access model for the led matrix block
// assumes read data answers one cycle after the request edge
`default_nettype none
module host_model (
    // register port
    input  wire logic                     clk_in,
    input  wire logic [7:0]               rdata_in,
    output var  led_matrix_pkg::reg_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import led_matrix_pkg::*;
    initial req_out = '0;
    task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, p, a, d};
        @(posedge clk_in);
        req_out <= '0;
    endtask : wr
    task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        req_out <= '{1'b0, 1'b1, p, a, 8'h00};
        @(posedge clk_in);
        req_out <= '0;
        @(posedge clk_in);
        v = rdata_in;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the led matrix brightness, detect and interrupt block
// assumes shortened timer parameters and the host model for register access
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import led_matrix_pkg::*;
    localparam int DC = 20;
    localparam int AC = 30;
    logic             clk_in;
    logic             rst_in;
    reg_req_t         req;
    logic [7:0]       rdata;
    logic [95:0]      open_in;
    logic [95:0]      short_in;
    logic [95:0][7:0] level;
    logic             intr_n;
    logic [7:0]       v;
    int               errors;
    int               cmp_count;
    int               n;
    host_model host (.clk_in, .rdata_in(rdata), .req_out(req));
    led_dot_mode_breath_detect_irq #(.DETECT_CYCLES(DC), .AUTO_CLEAR_CYCLES(AC), .BREATH_STEP_CYCLES(1)) DUT (
        .clk_in, .rst_in, .reg_req_in(req), .reg_rdata_out(rdata), .led_open_in(open_in),
        .led_short_in(short_in), .dot_level_out(level), .dot_enable_out(), .current_scale_out(),
        .interrupt_out_n(intr_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic rc(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
        host.rd(p, a, v);
        check(v, exp);
    endtask : rc
    // bounded wait for the interrupt level
    task automatic wait_int(input logic want, input int lim, output int k);
        k = 0;
        while (intr_n !== want) begin
            @(posedge clk_in);
            k++;
            if (k > lim) begin
                errors++;
                stop_test();
            end
        end
    endtask : wait_int
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        errors = 0;
        cmp_count = 0;
        rst_in = 1'b1;
        open_in = 96'h21;
        short_in = 96'h2;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        check({7'h00, intr_n}, 8'h01);
        host.wr(2'h3, 8'h01, 8'h01);
        rc(2'h3, 8'h01, 8'h01);
        host.wr(2'h0, 8'h00, 8'h0f);
        host.wr(2'h1, 8'h00, 8'h40);
        host.wr(2'h1, 8'h04, 8'h56);
        host.wr(2'h2, 8'h00, 8'h01);
        repeat (3) @(posedge clk_in);
        check(level[0], 8'h40);
        check(level[4], 8'h00);
        rc(2'h3, 8'h20, 8'h00);
        rc(2'h3, 8'h0e, 8'h00);
        // profile one: shortest ramps, one loop, stop at off
        host.wr(2'h3, 8'h05, 8'h01);
        host.wr(2'h3, 8'hf0, 8'h04);
        rc(2'h3, 8'h05, 8'h01);
        host.wr(2'h3, 8'h00, 8'h02);
        host.wr(2'h3, 8'h0e, 8'h00);
        repeat (4) @(posedge clk_in);
        check({7'h00, level[0] < 8'h20}, 8'h01);
        wait_int(1'b0, 2000, n);
        check({7'h00, n >= 500 && n <= 540}, 8'h01);
        rc(2'h3, 8'hf1, 8'h04);
        check({7'h00, intr_n}, 8'h01);
        rc(2'h3, 8'hf1, 8'h00);
        check(level[0], 8'h00);
        host.wr(2'h3, 8'h00, 8'h00);
        repeat (3) @(posedge clk_in);
        check(level[0], 8'h40);
        // detect with auto clear, open only in the mask
        host.wr(2'h3, 8'hf0, 8'h21);
        host.wr(2'h3, 8'h00, 8'h04);
        wait_int(1'b0, DC + 20, n);
        check({7'h00, n >= DC - 2}, 8'h01);
        rc(2'h0, 8'h18, 8'h01);
        rc(2'h0, 8'h30, 8'h02);
        wait_int(1'b1, AC + 10, n);
        check({7'h00, n >= AC - 12}, 8'h01);
        rc(2'h3, 8'hf1, 8'h00);
        host.wr(2'h3, 8'h00, 8'h04);
        repeat (DC + 10) @(posedge clk_in);
        check({7'h00, intr_n}, 8'h01);
        host.wr(2'h3, 8'h00, 8'h00);
        host.wr(2'h3, 8'h00, 8'h04);
        wait_int(1'b0, DC + 20, n);
        rc(2'h3, 8'hf1, 8'h01);
        stop_test();
    end
endmodule : tb
`default_nettype wire
